// ### rtl/odt_delay_timer.v
// On-delay, off-delay and on/off-delay timer with an APB register slave
// What this block does
// - On-delay: trigger rise clears elapsed count and starts it.
// - On-delay: output high at span if trigger stayed high throughout.
// - On-delay: trigger falling early discards the elapsed count.
// - On-delay: output low whenever trigger is low.
// - Retain option keeps elapsed count and output; else they clear.
// - Fixed span: 10 ms, 1 s or 1 min timebase with its maximum.
// - Referenced span: ms (max 99990), s or min (max 5999).
// - Out-of-range referenced span is clamped to nearest valid value.
// - Span source is fixed parameter or a selected block's live value.
// - Off-delay: output high at once when trigger rises.
// - Off-delay: trigger fall restarts elapsed count, output stays high.
// - Off-delay: output low when elapsed count reaches or passes span.
// - Off-delay: each new trigger pulse retriggers the count.
// - Off-delay: cancel clears count and drops output at once.
// - On/off-delay: trigger rise starts rise hold timing.
// - On/off-delay: trigger fall starts fall hold timing.
// - On/off-delay: output high at rise span if trigger still high.
// - On/off-delay: output low at fall span if trigger stayed low.
// - On/off-delay: early fall discards running on-delay time.
// - On/off-delay: early rise discards running off-delay time.
//
// The register addresses and the APB register port were decided locally.
`default_nettype none
`include "odt_regs.vh"
module odt_delay_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        trigger_in,
    input  wire        cancel_in,
    input  wire        power_restore,
    input  wire [255:0] ref_values,
    output reg         gated_output,
    output reg  [16:0] elapsed_count
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_RISE = 4'b0010;
    localparam [3:0] ST_ON   = 4'b0100;
    localparam [3:0] ST_FALL = 4'b1000;

    reg  [31:0] ctrl_q;
    reg  [31:0] span_a_q;
    reg  [31:0] span_b_q;
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [16:0] count_d;
    reg         out_d;
    reg         trig_q;
    reg  [31:0] tick_period;
    reg  [16:0] ref_live;
    integer     i;

    wire [1:0]  mode    = ctrl_q[`ODT_CTRL_MODE_LSB +: 2];
    wire [1:0]  tbase   = ctrl_q[`ODT_CTRL_TB_LSB +: 2];
    wire        use_ref = ctrl_q[`ODT_CTRL_SRC_BIT];
    wire        retain  = ctrl_q[`ODT_CTRL_RET_BIT];
    wire [3:0]  ref_sel = ctrl_q[`ODT_CTRL_SEL_LSB +: 4];
    wire        rise    = trigger_in & ~trig_q;
    wire        fall    = ~trigger_in & trig_q;
    wire        tick;
    wire        wr_en   = psel & penable & pwrite;
    wire        bad_adr;

    // Largest value a span may take for a timebase and source
    function [16:0] span_max;
        input [1:0] tb;
        input       from_ref;
        begin
            case (tb)
                `ODT_TB_SEC: span_max = `ODT_MAX_SEC;
                `ODT_TB_MIN: span_max = `ODT_MAX_MIN;
                default:     span_max = from_ref ? `ODT_MAX_FINE
                                                 : `ODT_PAR_MAX_FINE;
            endcase
        end
    endfunction

    // Clamp a raw value into the valid span range
    function [16:0] clamp_span;
        input [31:0] raw;
        input [16:0] lim;
        begin
            if (raw > {15'h0000, lim})
                clamp_span = lim;
            else
                clamp_span = raw[16:0];
        end
    endfunction

    // Referenced block values arrive as sixteen 16-bit words
    always @* begin
        ref_live = 17'h0_0000;
        for (i = 0; i < 16; i = i + 1) begin
            if (ref_sel == i[3:0])
                ref_live = {1'b0, ref_values[i*16 +: 16]};
        end
    end

    // Referenced ms count moves in 10 ms ticks
    wire [16:0] ref_scaled = (tbase == `ODT_TB_FINE) ?
                             ref_live / 17'h0_000A : ref_live;
    wire [16:0] lim_now    = span_max(tbase, use_ref);
    wire [16:0] span_on    = use_ref ?
        clamp_span({15'h0000, ref_scaled}, lim_now) :
        clamp_span(span_a_q, lim_now);
    wire [16:0] span_off   = use_ref ?
        clamp_span({15'h0000, ref_scaled}, lim_now) :
        clamp_span(span_b_q, lim_now);

    always @* begin
        case (tbase)
            `ODT_TB_SEC: tick_period = `ODT_TICK_S_CYC;
            `ODT_TB_MIN: tick_period = `ODT_TICK_MIN_CYC;
            default:     tick_period = `ODT_TICK_MS_CYC;
        endcase
    end

    odt_tick_gen u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (rise | fall),
        .period  (tick_period),
        .tick    (tick)
    );

    wire [16:0] inc   = elapsed_count + 17'h0_0001;
    wire        on_hit  = (elapsed_count >= span_on);
    wire        off_hit = (elapsed_count >= span_off);

    always @* begin
        state_d = state_q;
        count_d = elapsed_count;
        out_d   = gated_output;
        case (mode)
            `ODT_MODE_OFF: begin
                if (cancel_in) begin
                    count_d = 17'h0_0000;
                    out_d   = 1'b0;
                    state_d = ST_IDLE;
                end else if (trigger_in) begin
                    out_d   = 1'b1;
                    count_d = 17'h0_0000;
                    state_d = ST_ON;
                end else if (fall) begin
                    count_d = 17'h0_0000;
                    state_d = ST_FALL;
                end else if (state_q == ST_FALL) begin
                    if (off_hit) begin
                        out_d   = 1'b0;
                        state_d = ST_IDLE;
                    end else if (tick) begin
                        count_d = inc;
                    end
                end
            end
            `ODT_MODE_ONOFF: begin
                case (state_q)
                    ST_IDLE, ST_RISE: begin
                        if (!trigger_in) begin
                            count_d = 17'h0_0000;
                            state_d = ST_IDLE;
                        end else if (state_q == ST_IDLE || rise) begin
                            count_d = 17'h0_0000;
                            state_d = ST_RISE;
                        end else if (on_hit) begin
                            out_d   = 1'b1;
                            state_d = ST_ON;
                        end else if (tick) begin
                            count_d = inc;
                        end
                    end
                    ST_ON, ST_FALL: begin
                        if (trigger_in) begin
                            count_d = 17'h0_0000;
                            state_d = ST_ON;
                        end else if (state_q == ST_ON || fall) begin
                            count_d = 17'h0_0000;
                            state_d = ST_FALL;
                        end else if (off_hit) begin
                            out_d   = 1'b0;
                            state_d = ST_IDLE;
                        end else if (tick) begin
                            count_d = inc;
                        end
                    end
                    default: begin
                        state_d = ST_IDLE;
                        out_d   = 1'b0;
                    end
                endcase
            end
            default: begin
                if (!trigger_in) begin
                    count_d = 17'h0_0000;
                    out_d   = 1'b0;
                    state_d = ST_IDLE;
                end else if (rise || state_q == ST_IDLE) begin
                    count_d = 17'h0_0000;
                    out_d   = 1'b0;
                    state_d = ST_RISE;
                end else if (state_q == ST_RISE) begin
                    if (on_hit) begin
                        out_d   = 1'b1;
                        state_d = ST_ON;
                    end else if (tick) begin
                        count_d = inc;
                    end
                end
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= ST_IDLE;
            elapsed_count <= 17'h0_0000;
            gated_output  <= 1'b0;
            trig_q        <= 1'b0;
        end else if (power_restore && !retain) begin
            state_q       <= ST_IDLE;
            elapsed_count <= 17'h0_0000;
            gated_output  <= 1'b0;
            trig_q        <= trigger_in;
        end else begin
            state_q       <= state_d;
            elapsed_count <= count_d;
            gated_output  <= out_d;
            trig_q        <= trigger_in;
        end
    end

    assign bad_adr = (paddr != `ODT_ADDR_CTRL) &&
                     (paddr != `ODT_ADDR_SPAN_A) &&
                     (paddr != `ODT_ADDR_SPAN_B) &&
                     (paddr != `ODT_ADDR_STATUS) &&
                     (paddr != `ODT_ADDR_ELAPSED);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & bad_adr;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `ODT_CTRL_RST;
            span_a_q <= `ODT_SPAN_RST;
            span_b_q <= `ODT_SPAN_RST;
        end else if (wr_en) begin
            case (paddr)
                `ODT_ADDR_CTRL:   ctrl_q   <= pwdata & 32'h0000_0F3F;
                `ODT_ADDR_SPAN_A: span_a_q <= pwdata;
                `ODT_ADDR_SPAN_B: span_b_q <= pwdata;
                default:          ctrl_q   <= ctrl_q;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `ODT_ADDR_CTRL:    prdata <= ctrl_q;
                `ODT_ADDR_SPAN_A:  prdata <= span_a_q;
                `ODT_ADDR_SPAN_B:  prdata <= span_b_q;
                `ODT_ADDR_STATUS:  prdata <= {26'h000_0000, state_q,
                                              trigger_in, gated_output};
                `ODT_ADDR_ELAPSED: prdata <= {15'h0000, elapsed_count};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // odt_delay_timer
`default_nettype wire

// ### rtl/odt_regs.vh
// Offsets, fields, reset values and timing counts of the delay timer
`ifndef ODT_REGS_VH
`define ODT_REGS_VH
`define ODT_CLK_HZ         50000000
`define ODT_TICK_MS_NS     10000000
`define ODT_TICK_MS_CYC    ((`ODT_TICK_MS_NS / 20))
`define ODT_TICK_S_CYC     (`ODT_CLK_HZ)
`define ODT_TICK_MIN_CYC   32'hB2D0_5E00
`define ODT_ADDR_CTRL      12'h000
`define ODT_ADDR_SPAN_A    12'h004
`define ODT_ADDR_SPAN_B    12'h008
`define ODT_ADDR_STATUS    12'h00C
`define ODT_ADDR_ELAPSED   12'h010
`define ODT_CTRL_MODE_LSB  0
`define ODT_CTRL_TB_LSB    2
`define ODT_CTRL_SRC_BIT   4
`define ODT_CTRL_RET_BIT   5
`define ODT_CTRL_SEL_LSB   8
`define ODT_CTRL_RST       32'h0000_0000
`define ODT_SPAN_RST       32'h0000_0000
`define ODT_MODE_ON        2'h0
`define ODT_MODE_OFF       2'h1
`define ODT_MODE_ONOFF     2'h2
`define ODT_TB_FINE        2'h0
`define ODT_TB_SEC         2'h1
`define ODT_TB_MIN         2'h2
`define ODT_MAX_FINE       17'h0_270F
`define ODT_MAX_SEC        17'h0_176F
`define ODT_MAX_MIN        17'h0_176F
`define ODT_PAR_MAX_FINE   17'h0_270F
`endif

// ### rtl/odt_tick_gen.v
// Timebase tick prescaler for the delay timer
`default_nettype none
module odt_tick_gen (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        restart,
    input  wire [31:0] period,
    output reg         tick
);
    reg [31:0] cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (restart) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_q + 32'h0000_0001 >= period) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule // odt_tick_gen
`default_nettype wire

// ### dv/odt_timer_checker.sv
// Port-level assertion checker for the delay timer
`default_nettype none
module odt_timer_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        trigger_in,
    input wire logic        cancel_in,
    input wire logic        power_restore,
    input wire logic [16:0] elapsed_count,
    input wire logic        gated_output
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] ctrl_q;
    logic       bad_addr;
    assign bad_addr = (paddr > 12'h010) || (paddr[1:0] != 2'h0);
    // Shadow of mode and retain bits, taken at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= 6'h00;
        else if (psel && penable && pwrite && paddr == 12'h000)
            ctrl_q <= pwdata[5:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ERR_MAP:
        assert property (psel && penable |-> pslverr == bad_addr)
        else $error("slave error does not match address map");
    AST_RD_ZERO:
        assert property (psel && penable && !pwrite && bad_addr
            |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    AST_ON_LOW:
        assert property ((ctrl_q[1:0] == 2'h0 && !trigger_in) [*3]
            |-> !gated_output)
        else $error("on-delay output high with trigger low");
    AST_ON_RISE:
        assert property (ctrl_q[1:0] == 2'h0 && $rose(gated_output)
            |-> $past(trigger_in) && $past(trigger_in, 2))
        else $error("on-delay output rose without steady trigger");
    AST_OFF_RISE:
        assert property ((ctrl_q[1:0] == 2'h1 && $rose(trigger_in)
            && !cancel_in && !power_restore) ##1 (!cancel_in
            && !power_restore) |-> ##[0:1] gated_output)
        else $error("off-delay output late after trigger rise");
    AST_CANCEL:
        assert property (ctrl_q[1:0] == 2'h1 && cancel_in
            |-> ##[1:2] (!gated_output && elapsed_count == 17'h0_0000))
        else $error("cancel did not clear output and count");
    AST_NO_RETAIN:
        assert property (power_restore && !ctrl_q[5]
            |=> !gated_output && elapsed_count == 17'h0_0000)
        else $error("state kept over restore without retain");
    AST_ONOFF_SET:
        assert property (ctrl_q[1:0] == 2'h2 && $rose(gated_output)
            |-> $past(trigger_in))
        else $error("on/off output set while trigger low");
    AST_ONOFF_CLR:
        assert property (ctrl_q[1:0] == 2'h2 && $fell(gated_output)
            && !$past(power_restore) |-> !$past(trigger_in))
        else $error("on/off output cleared while trigger high");
    AST_STEP:
        assert property ($changed(elapsed_count) |-> elapsed_count ==
            17'h0_0000 || elapsed_count == $past(elapsed_count) + 17'h1)
        else $error("elapsed count jumped by more than one");
endmodule // odt_timer_checker
bind odt_delay_timer odt_timer_checker i_chk (.*);
`default_nettype wire

// ### dv/odt_ctl_model.sv
// Control-logic model that drives trigger and cancel levels
`default_nettype none
module odt_ctl_model (
    input  wire logic pclk,
    input  wire logic want_trig,
    input  wire logic want_cancel,
    output var  logic trigger_in,
    output var  logic cancel_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        trigger_in = 1'b0;
        cancel_in  = 1'b0;
    end
    // Levels change only just after a clock edge
    always @(posedge pclk) begin
        trigger_in <= want_trig;
        cancel_in  <= want_cancel;
    end
endmodule // odt_ctl_model
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the delay timer
`default_nettype none
`include "odt_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic        err;
        logic [31:0] mask;
        logic [31:0] val;
    } odt_note_t;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         trigger_in, cancel_in, power_restore, gated_output;
    logic         want_trig, want_cancel;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, lfsr_q;
    logic [255:0] ref_values;
    logic [16:0]  elapsed_count;
    int           errors = 0;
    int           n_tests = 0;
    odt_note_t    notes[$];
    odt_delay_timer i_dut (.*);
    odt_ctl_model   i_ctl (.*);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input [11:0] a, input [31:0] m, v, input logic e);
        notes.push_back('{e, m, v});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic step(input logic t, c);
        @(posedge pclk);
        want_trig <= t;
        want_cancel <= c;
        repeat (6) @(posedge pclk);
    endtask
    task automatic restore;
        @(posedge pclk);
        power_restore <= 1'b1;
        @(posedge pclk);
        power_restore <= 1'b0;
    endtask
    task automatic summarize;
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Read results are compared with the oldest note in order
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check($sformatf("rd %h", paddr), prdata & notes[0].mask,
                notes[0].val);
            check("pslverr", {31'h0, pslverr}, {31'h0, notes[0].err});
            void'(notes.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, power_restore} = 5'h00;
        {want_trig, want_cancel, paddr, pwdata} = '0;
        lfsr_q = 32'h8feb_af2d;
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            ref_values[i*32 +: 32] = lfsr_q;
        end
        ref_values[63:48] = 16'h0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ODT_ADDR_CTRL, '1, `ODT_CTRL_RST, 1'b0);
        rd(`ODT_ADDR_SPAN_A, '1, `ODT_SPAN_RST, 1'b0);
        rd(`ODT_ADDR_SPAN_B, '1, `ODT_SPAN_RST, 1'b0);
        rd(`ODT_ADDR_ELAPSED, '1, 32'h0000_0000, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h0000_0003, 32'h0000_0000, 1'b0);
        repeat (3) begin
            lfsr_q = lfsr_next(lfsr_q);
            apb(1'b1, {4'h1, lfsr_q[7:2], 2'h0}, lfsr_q);
            rd({4'h1, lfsr_q[7:2], 2'h0}, '1, 32'h0000_0000, 1'b1);
        end
        rd(`ODT_ADDR_CTRL, '1, `ODT_CTRL_RST, 1'b0);
        apb(1'b1, `ODT_ADDR_CTRL, 32'h0000_0A2A);
        rd(`ODT_ADDR_CTRL, '1, 32'h0000_0A2A, 1'b0);
        lfsr_q = lfsr_next(lfsr_q);
        apb(1'b1, `ODT_ADDR_SPAN_B, {19'h0, lfsr_q[12:1], 1'b1});
        rd(`ODT_ADDR_SPAN_B, '1, {19'h0, lfsr_q[12:1], 1'b1}, 1'b0);
        apb(1'b1, `ODT_ADDR_SPAN_A, 32'h0000_0064);
        apb(1'b1, `ODT_ADDR_CTRL, 32'h0000_0001);
        step(1'b1, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h3, 1'b0);
        step(1'b0, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h1, 1'b0);
        rd(`ODT_ADDR_ELAPSED, '1, 32'h0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h1, 1'b0);
        step(1'b0, 1'b1);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h0, 1'b0);
        rd(`ODT_ADDR_ELAPSED, '1, 32'h0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        restore();
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h0, 1'b0);
        apb(1'b1, `ODT_ADDR_CTRL, 32'h0000_0021);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        restore();
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h1, 1'b0);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
        apb(1'b1, `ODT_ADDR_CTRL, 32'h0000_0000);
        step(1'b1, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h2, 1'b0);
        step(1'b0, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h0, 1'b0);
        rd(`ODT_ADDR_ELAPSED, '1, 32'h0, 1'b0);
        apb(1'b1, `ODT_ADDR_SPAN_A, 32'h0000_0000);
        apb(1'b1, `ODT_ADDR_CTRL, 32'h0000_0002);
        step(1'b1, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h3, 1'b0);
        step(1'b0, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h1, 1'b0);
        step(1'b1, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h3, 1'b0);
        step(1'b0, 1'b0);
        apb(1'b1, `ODT_ADDR_SPAN_A, 32'h0000_0064);
        apb(1'b1, `ODT_ADDR_CTRL, 32'h0000_0310);
        step(1'b1, 1'b0);
        rd(`ODT_ADDR_STATUS, 32'h3, 32'h3, 1'b0);
        step(1'b0, 1'b0);
        summarize();
    end
endmodule // tb
`default_nettype wire
